// ===== pkg/rsd_pkg.sv
// constants shared by the rail sequence and delay configuration block
package rsd_pkg;

	// subaddresses of the register file
	localparam logic [7:0] RSD_ADDR_REG_VOLT = 8'h1B;
	localparam logic [7:0] RSD_ADDR_SEQ_LOW = 8'h20;
	localparam logic [7:0] RSD_ADDR_SEQ_HIGH = 8'h21;

	// reset values
	localparam logic [5:0] RSD_VOLT_RESET = 6'h3D;
	localparam logic [7:0] RSD_SEQ_LOW_RESET = 8'h00;
	localparam logic [7:0] RSD_SEQ_HIGH_RESET = 8'h00;

	// field layout of the second sequencer register, and the padding of the voltage readback
	localparam int RSD_PAUSE9_BIT = 0;
	localparam int RSD_PD_MULT_BIT = 7;
	localparam logic [7:0] RSD_SEQ_HIGH_MASK = 8'h81;
	localparam logic [1:0] RSD_VOLT_PAD = 2'h0;

	// strobe numbering
	localparam int RSD_NUM_PAUSES = 9;
	localparam logic [3:0] RSD_STROBE_FIRST = 4'h1;
	localparam logic [3:0] RSD_STROBE_LAST = 4'hA;
	localparam logic [3:0] RSD_STROBE_ONE = 4'h1;
	localparam logic [3:0] RSD_STROBE_TWO = 4'h2;
	localparam logic [3:0] RSD_ASSIGN_MIN = 4'h3;
	localparam logic [3:0] RSD_ASSIGN_MAX = 4'hA;

	// timing, in milliseconds, and the clock rate in kHz
	localparam int RSD_CLK_KHZ = 40000;
	localparam int RSD_SHORT_PAUSE_MS = 2;
	localparam int RSD_LONG_PAUSE_MS = 5;
	localparam int RSD_BLANK_MS = 5;
	localparam logic [23:0] RSD_PD_FACTOR = 24'h00_000A;
	localparam logic [23:0] RSD_CNT_ONE = 24'h00_0001;
	localparam logic [23:0] RSD_CNT_ZERO = 24'h00_0000;

	typedef enum logic [1:0] {
		RSD_IDLE = 2'b01,
		RSD_PAUSE = 2'b10
	} rsd_state_t;

endpackage

// ===== verilog/rsd_seq_cfg.sv
// register file, voltage blanking timer and strobe sequencer
`timescale 1ns/10ps
module rsd_seq_cfg import rsd_pkg::*; #(
	parameter logic [23:0] SHORT_CYC = 24'(RSD_SHORT_PAUSE_MS * RSD_CLK_KHZ),
	parameter logic [23:0] LONG_CYC = 24'(RSD_LONG_PAUSE_MS * RSD_CLK_KHZ),
	parameter logic [23:0] BLANK_CYC = 24'(RSD_BLANK_MS * RSD_CLK_KHZ)
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	input wire logic pw_unlock,
	input wire logic seq_up_req,
	input wire logic seq_down_req,
	input wire logic [3:0] rail_assign_code,
	output logic [5:0] aux_regulator_voltage_code,
	output logic monitor_blank,
	output logic strobe_pulse,
	output logic [3:0] strobe_num,
	output logic seq_busy,
	output logic rail_seq_en
);

	typedef struct packed {
		logic [7:0] seq_low;
		logic [7:0] seq_high;
		logic [5:0] volt;
		logic unlocked;
		logic blank;
		logic [23:0] blank_cnt;
		rsd_state_t state;
		logic down;
		logic [3:0] strobe;
		logic [23:0] pause_cnt;
		logic pulse;
		logic rail_en;
		logic [7:0] rdata;
		logic ack;
	} rsd_regs_t;

	rsd_regs_t st_r;
	rsd_regs_t st_nxt;
	logic [RSD_NUM_PAUSES-1:0] pause_sel;
	logic wr_volt_ok;
	logic [23:0] next_len;

	// ***************************************
	// pause selection
	// ***************************************
	assign pause_sel = {st_r.seq_high[RSD_PAUSE9_BIT], st_r.seq_low};

	// length of the pause that follows the strobe just issued, in cycles
	function automatic logic [23:0] pause_len(input logic [RSD_NUM_PAUSES-1:0] sel,
		input logic down, input logic mult, input logic [3:0] strobe);
		logic [3:0] idx;
		logic [23:0] base;
		idx = down ? strobe - RSD_STROBE_TWO : strobe - RSD_STROBE_ONE;
		if (int'(idx) < RSD_NUM_PAUSES) begin
			base = sel[idx] ? LONG_CYC : SHORT_CYC;
		end else begin
			// trailing pause after the last strobe has no delay bit, keep it short
			base = SHORT_CYC;
		end
		if (down && mult) begin
			base = 24'(base * RSD_PD_FACTOR);
		end
		return base;
	endfunction

	// ***************************************
	// next state
	// ***************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.pulse = 1'b0;
		st_nxt.ack = reg_wr | reg_rd;
		wr_volt_ok = reg_wr && st_r.unlocked && reg_addr == RSD_ADDR_REG_VOLT;
		next_len = RSD_CNT_ZERO;
		// register writes, protected by the unlock flag
		if (reg_wr && st_r.unlocked) begin
			if (reg_addr == RSD_ADDR_REG_VOLT) begin
				st_nxt.volt = reg_wdata[5:0];
				st_nxt.unlocked = 1'b0;
			end else if (reg_addr == RSD_ADDR_SEQ_LOW) begin
				st_nxt.seq_low = reg_wdata;
				st_nxt.unlocked = 1'b0;
			end else if (reg_addr == RSD_ADDR_SEQ_HIGH) begin
				st_nxt.seq_high = reg_wdata & RSD_SEQ_HIGH_MASK;
				st_nxt.unlocked = 1'b0;
			end
		end
		// a new unlock in the same cycle as a consuming write survives
		if (pw_unlock) begin
			st_nxt.unlocked = 1'b1;
		end
		// reads, unmapped subaddresses answer zero
		if (reg_rd) begin
			if (reg_addr == RSD_ADDR_REG_VOLT) begin
				st_nxt.rdata = {RSD_VOLT_PAD, st_r.volt};
			end else if (reg_addr == RSD_ADDR_SEQ_LOW) begin
				st_nxt.rdata = st_r.seq_low;
			end else if (reg_addr == RSD_ADDR_SEQ_HIGH) begin
				st_nxt.rdata = st_r.seq_high;
			end else begin
				st_nxt.rdata = 8'h00;
			end
		end
		// monitor blanking after a regulator voltage write
		if (wr_volt_ok) begin
			st_nxt.blank = 1'b1;
			st_nxt.blank_cnt = BLANK_CYC - RSD_CNT_ONE;
		end else if (st_r.blank) begin
			if (st_r.blank_cnt == RSD_CNT_ZERO) begin
				st_nxt.blank = 1'b0;
			end else begin
				st_nxt.blank_cnt = st_r.blank_cnt - RSD_CNT_ONE;
			end
		end
		// strobe sequencer
		case (st_r.state)
			RSD_IDLE: begin
				if (seq_up_req || seq_down_req) begin
					st_nxt.down = ~seq_up_req;
					st_nxt.strobe = seq_up_req ? RSD_STROBE_FIRST : RSD_STROBE_LAST;
					st_nxt.pulse = 1'b1;
					next_len = pause_len(pause_sel, ~seq_up_req,
						st_r.seq_high[RSD_PD_MULT_BIT], st_nxt.strobe);
					st_nxt.pause_cnt = next_len - RSD_CNT_ONE;
					st_nxt.state = RSD_PAUSE;
				end
			end
			RSD_PAUSE: begin
				if (st_r.pause_cnt != RSD_CNT_ZERO) begin
					st_nxt.pause_cnt = st_r.pause_cnt - RSD_CNT_ONE;
				end else if ((!st_r.down && st_r.strobe == RSD_STROBE_LAST) ||
					(st_r.down && st_r.strobe == RSD_STROBE_FIRST)) begin
					st_nxt.state = RSD_IDLE;
				end else begin
					st_nxt.strobe = st_r.down ? st_r.strobe - RSD_STROBE_ONE :
						st_r.strobe + RSD_STROBE_ONE;
					st_nxt.pulse = 1'b1;
					next_len = pause_len(pause_sel, st_r.down,
						st_r.seq_high[RSD_PD_MULT_BIT], st_nxt.strobe);
					st_nxt.pause_cnt = next_len - RSD_CNT_ONE;
				end
			end
			default: begin
				st_nxt.state = RSD_IDLE;
			end
		endcase
		// rail switches at its assigned strobe, codes outside range never sequence
		if (st_nxt.pulse && rail_assign_code >= RSD_ASSIGN_MIN &&
			rail_assign_code <= RSD_ASSIGN_MAX && st_nxt.strobe == rail_assign_code) begin
			st_nxt.rail_en = ~st_nxt.down;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '{seq_low: RSD_SEQ_LOW_RESET, seq_high: RSD_SEQ_HIGH_RESET,
				volt: RSD_VOLT_RESET, state: RSD_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign reg_ack = st_r.ack;
	assign aux_regulator_voltage_code = st_r.volt;
	assign monitor_blank = st_r.blank;
	assign strobe_pulse = st_r.pulse;
	assign strobe_num = st_r.strobe;
	assign seq_busy = st_r.state == RSD_PAUSE;
	assign rail_seq_en = st_r.rail_en;

	// ***************************************
	// assertions
	// ***************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_locked_write;
		reg_wr && !st_r.unlocked;
	endsequence

	sequence s_next_strobe;
		st_r.state == RSD_PAUSE && st_r.pause_cnt == RSD_CNT_ZERO &&
		!((!st_r.down && st_r.strobe == RSD_STROBE_LAST) ||
		(st_r.down && st_r.strobe == RSD_STROBE_FIRST));
	endsequence

	chk_locked_volt_hold: assert property (
		s_locked_write |=> $stable(st_r.volt) && $stable(st_r.seq_low) && $stable(st_r.seq_high))
		else $error("protected register changed without unlock");

	chk_blank_start_len: assert property (
		wr_volt_ok |=> st_r.blank && st_r.blank_cnt == BLANK_CYC - RSD_CNT_ONE)
		else $error("voltage write did not start full blanking");

	chk_seq_low_write: assert property (
		reg_wr && st_r.unlocked && reg_addr == RSD_ADDR_SEQ_LOW |=>
		st_r.seq_low == $past(reg_wdata))
		else $error("first sequencer register write lost");

	chk_seq_high_read: assert property (
		reg_rd && reg_addr == RSD_ADDR_SEQ_HIGH |=> reg_ack &&
		(reg_rdata & ~RSD_SEQ_HIGH_MASK) == 8'h00)
		else $error("reserved bits of second sequencer register not zero");

	chk_volt_read: assert property (
		reg_rd && !reg_wr && reg_addr == RSD_ADDR_REG_VOLT |=>
		reg_rdata == {RSD_VOLT_PAD, $past(st_r.volt)})
		else $error("regulator code readback wrong");

	chk_pause_select: assert property (
		st_r.pulse && !st_r.down && st_r.strobe != RSD_STROBE_LAST |-> st_r.pause_cnt ==
		(pause_sel[st_r.strobe - RSD_STROBE_ONE] ? LONG_CYC : SHORT_CYC) - RSD_CNT_ONE)
		else $error("power-up pause length does not match delay bit");

	chk_down_factor: assert property (
		st_r.pulse && st_r.down && st_r.strobe != RSD_STROBE_FIRST |-> st_r.pause_cnt ==
		(st_r.seq_high[RSD_PD_MULT_BIT] ? 24'(RSD_PD_FACTOR *
		(pause_sel[st_r.strobe - RSD_STROBE_TWO] ? LONG_CYC : SHORT_CYC)) :
		(pause_sel[st_r.strobe - RSD_STROBE_TWO] ? LONG_CYC : SHORT_CYC)) - RSD_CNT_ONE)
		else $error("power-down pause length wrong");

	chk_strobe_step: assert property (
		s_next_strobe |=> st_r.pulse && st_r.strobe == (st_r.down ?
		$past(st_r.strobe) - RSD_STROBE_ONE : $past(st_r.strobe) + RSD_STROBE_ONE))
		else $error("strobe did not advance by one");

	chk_rail_enable: assert property (
		st_r.pulse && !st_r.down && st_r.strobe == rail_assign_code &&
		rail_assign_code >= RSD_ASSIGN_MIN |-> st_r.rail_en)
		else $error("rail not enabled at its strobe");

endmodule // rsd_seq_cfg

// ===== verif/rsd_host_model.sv
// host model that programs the block through its register port
`timescale 1ns/10ps
module rsd_host_model (
	input wire logic sys_clk,
	input wire logic reg_ack,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic pw_unlock
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pw_unlock = 1'b0;
	end

	// one byte transfer; u arms the protected write just before it
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w,
		input logic u, output logic [7:0] q);
		int n;
		if (u) begin
			@(posedge sys_clk);
			pw_unlock <= 1'b1;
		end
		@(posedge sys_clk);
		pw_unlock <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= ~w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (reg_ack !== 1'b1 && n < 8);
		q = reg_rdata;
		if (n == 8) rsd_seq_cfg_tb.timeout();
	endtask
endmodule // rsd_host_model

// ===== verif/rsd_seq_cfg_tb.sv
// self-checking bench for the sequencer configuration block
`timescale 1ns/10ps
module rsd_seq_cfg_tb import rsd_pkg::*;;
	localparam int SHORT_T = 4;
	localparam int LONG_T = 10;
	localparam int BLANK_T = 12;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic seq_up_req = 1'b0;
	logic seq_down_req = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_ack, pw_unlock, monitor_blank, strobe_pulse, seq_busy, rail_seq_en;
	logic [5:0] aux_regulator_voltage_code;
	logic [3:0] strobe_num;
	logic [3:0] rail_code = 4'h3;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int blank_n = 0;

	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (monitor_blank === 1'b1) blank_n <= blank_n + 1;
	end

	rsd_seq_cfg #(.SHORT_CYC(24'h00_0004), .LONG_CYC(24'h00_000A), .BLANK_CYC(24'h00_000C))
	i_rsd_seq_cfg (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.pw_unlock(pw_unlock), .seq_up_req(seq_up_req), .seq_down_req(seq_down_req),
		.rail_assign_code(rail_code), .aux_regulator_voltage_code(aux_regulator_voltage_code),
		.monitor_blank(monitor_blank), .strobe_pulse(strobe_pulse), .strobe_num(strobe_num),
		.seq_busy(seq_busy), .rail_seq_en(rail_seq_en));
	rsd_host_model i_rsd_host_model (.sys_clk(sys_clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.pw_unlock(pw_unlock));

	task automatic give_verdict();
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic timeout();
		err_total++;
		give_verdict();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
		logic [7:0] q;
		i_rsd_host_model.xfer(a, d, 1'b1, u, q);
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		i_rsd_host_model.xfer(a, 8'h00, 1'b0, 1'b0, q);
		chk(nm, e, q);
	endtask
	task automatic wait_strobe(output int t);
		for (int n = 0; n < 2000; n++) begin
			@(posedge sys_clk);
			if (strobe_pulse === 1'b1) begin
				t = cyc;
				return;
			end
		end
		timeout();
	endtask

	// ***************************
	// scenarios
	// ***************************
	task automatic t_reset();
		rd_chk("seq_low", RSD_ADDR_SEQ_LOW, 8'h00);
		rd_chk("seq_high", RSD_ADDR_SEQ_HIGH, 8'h00);
		rd_chk("volt", RSD_ADDR_REG_VOLT, 8'h3D);
		chk("code", 6'h3D, aux_regulator_voltage_code);
		rd_chk("unmapped", 8'h30, 8'h00);
	endtask
	task automatic t_protect();
		wr(RSD_ADDR_SEQ_LOW, 8'hA5, 1'b0);
		rd_chk("locked", RSD_ADDR_SEQ_LOW, 8'h00);
		wr(RSD_ADDR_SEQ_LOW, 8'hA5, 1'b1);
		rd_chk("seq_low", RSD_ADDR_SEQ_LOW, 8'hA5);
		wr(RSD_ADDR_SEQ_LOW, 8'hFF, 1'b0);
		rd_chk("relocked", RSD_ADDR_SEQ_LOW, 8'hA5);
		wr(RSD_ADDR_SEQ_HIGH, 8'hFF, 1'b1);
		rd_chk("seq_high", RSD_ADDR_SEQ_HIGH, 8'h81);
	endtask
	task automatic t_volt();
		int n;
		n = blank_n;
		wr(RSD_ADDR_REG_VOLT, 8'hEA, 1'b1);
		repeat (20) @(posedge sys_clk);
		chk("blank", BLANK_T, blank_n - n);
		chk("code", 6'h2A, aux_regulator_voltage_code);
		rd_chk("volt", RSD_ADDR_REG_VOLT, 8'h2A);
	endtask
	// bits are {0x21[0], 0x20}, fct the power-down factor, ok says rail code is in range
	task automatic t_seq(input logic dn, input logic [8:0] bits, input int fct, input logic ok);
		int i, t0, t1, e, x;
		@(posedge sys_clk);
		seq_up_req <= ~dn;
		seq_down_req <= dn;
		@(posedge sys_clk);
		seq_up_req <= 1'b0;
		seq_down_req <= 1'b0;
		for (i = 1; i <= 10; i++) begin
			wait_strobe(t1);
			e = dn ? 11 - i : i;
			chk("strobe", e, strobe_num);
			chk("busy", 1, seq_busy);
			if (i > 1) begin
				x = (bits[dn ? e - 1 : e - 2] ? LONG_T : SHORT_T) * (dn ? fct : 1);
				chk("pause", x, t1 - t0);
			end
			if (e == 3 || e == 4) chk("rail", ok && (!dn || e == 4), rail_seq_en);
			t0 = t1;
		end
		for (i = 0; i < 2000 && seq_busy !== 1'b0; i++) @(posedge sys_clk);
		if (i == 2000) timeout();
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_protect();
		t_volt();
		t_seq(1'b0, 9'h1A5, 10, 1'b1);
		t_seq(1'b1, 9'h1A5, 10, 1'b1);
		// factor cleared, rail code outside the strobe range
		wr(RSD_ADDR_SEQ_HIGH, 8'h01, 1'b1);
		rail_code <= 4'hB;
		t_seq(1'b0, 9'h1A5, 1, 1'b0);
		t_seq(1'b1, 9'h1A5, 1, 1'b0);
		// reset after the last run has ended must restore every register
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		give_verdict();
	end
endmodule // rsd_seq_cfg_tb
